//--- hw/gghd_device.sv
// Instrument end: remote/local, lockout, addressing, clears and trigger.
`timescale 1ns/1ps
module gghd_device #(
  parameter logic [4:0] PRIMARY_ADDR = gghd_pkg::DEFAULT_PRIMARY_ADDR
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  gghd_bus_if.dev                         bus,
  input  wire logic                       panel_local_key,
  input  wire logic                       panel_set_we,
  input  wire gghd_pkg::gghd_settings_type panel_set_data,
  output logic                            remote_led,
  output logic                            talk_led,
  output logic                            listen_led,
  output logic                            panel_locked,
  output logic                            trigger_reading,
  output gghd_pkg::gghd_settings_type     settings
);
  import gghd_pkg::*;

  // -----------------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------------
  // The all-ones code means unaddress and cannot be a device address.
  if (PRIMARY_ADDR == UNADDR_CODE) begin : g_bad_addr
    $error("Primary address 31 is reserved for unaddress.");
  end

  // -----------------------------------------------------------------------
  // Bus line synchronisers
  // -----------------------------------------------------------------------
  localparam int SW = 12;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic          dav3_q;
  logic          atn_s;
  logic          ren_s;
  logic          ifc_s;
  logic          dav_s;
  logic [7:0]    dio_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      dav3_q  <= 1'b0;
    end else begin
      sync1_q <= {bus.atn, bus.ren, bus.ifc, bus.dav, bus.dio};
      sync2_q <= sync1_q;
      dav3_q  <= dav_s;
    end
  end

  always_comb begin
    {atn_s, ren_s, ifc_s, dav_s, dio_s} = sync2_q;
  end

  // -----------------------------------------------------------------------
  // Command decode
  // -----------------------------------------------------------------------
  // Bytes are taken on the rising edge of the synchronised data valid,
  // so the sender must hold the byte steady for the whole valid phase.
  logic byte_stb;
  logic cmd_valid;
  logic is_mla;
  logic is_unl;
  logic is_mta;
  logic is_untalk;
  logic is_gtl;
  logic is_sdc;
  logic is_get;
  logic is_llo;
  logic is_dcl;

  always_comb begin
    byte_stb  = dav_s && !dav3_q;
    cmd_valid = byte_stb && atn_s;
  end

  gghd_cmd_decode u_decode (
    .cmd_byte  (dio_s),
    .cmd_valid (cmd_valid),
    .my_addr   (PRIMARY_ADDR),
    .is_mla    (is_mla),
    .is_unl    (is_unl),
    .is_mta    (is_mta),
    .is_untalk (is_untalk),
    .is_gtl    (is_gtl),
    .is_sdc    (is_sdc),
    .is_get    (is_get),
    .is_llo    (is_llo),
    .is_dcl    (is_dcl)
  );

  // -----------------------------------------------------------------------
  // Interface state
  // -----------------------------------------------------------------------
  logic              remote_q;
  logic              remote_d;
  logic              llo_q;
  logic              llo_d;
  logic              listen_q;
  logic              listen_d;
  logic              talk_q;
  logic              talk_d;
  logic              trig_q;
  logic              trig_d;
  logic              dev_clear;
  logic              one_shot;
  gghd_settings_type set_q;
  gghd_settings_type set_d;

  always_comb begin
    remote_d  = remote_q;
    llo_d     = llo_q;
    listen_d  = listen_q;
    talk_d    = talk_q;
    set_d     = set_q;
    trig_d    = 1'b0;
    one_shot  = (set_q.trig == one_shot_talk_trigger_mode) ||
                (set_q.trig == one_shot_get_trigger_mode);
    dev_clear = is_dcl || (is_sdc && listen_q);

    // Addressing follows the listen and talk address groups.
    if (is_mla) begin
      listen_d = 1'b1;
    end else if (is_unl) begin
      listen_d = 1'b0;
    end
    if (is_mta) begin
      talk_d = 1'b1;
    end else if (is_untalk) begin
      talk_d = 1'b0;
    end

    // Remote and lockout live only while REN is asserted.
    if (!ren_s) begin
      remote_d = 1'b0;
      llo_d    = 1'b0;
    end else begin
      if (is_mla) begin
        remote_d = 1'b1;
      end
      if (is_llo) begin
        llo_d = 1'b1;
      end
      if (is_gtl && listen_q) begin
        remote_d = 1'b0;
      end
    end

    // The local key is a front-panel control, so lockout blocks it too.
    if (panel_local_key && !llo_q) begin
      remote_d = 1'b0;
    end
    if (panel_set_we && !llo_q && !remote_q) begin
      set_d = panel_set_data;
    end

    // A bus clear wins over a panel change made in the same cycle.
    if (dev_clear) begin
      set_d = SETTINGS_RESET;
    end
    if (is_get && listen_q && one_shot) begin
      trig_d = 1'b1;
    end

    // Interface clear overrides every address and remote change.
    if (ifc_s) begin
      listen_d = 1'b0;
      talk_d   = 1'b0;
      remote_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_q <= 1'b0;
      llo_q    <= 1'b0;
      listen_q <= 1'b0;
      talk_q   <= 1'b0;
      trig_q   <= 1'b0;
      set_q    <= SETTINGS_RESET;
    end else begin
      remote_q <= remote_d;
      llo_q    <= llo_d;
      listen_q <= listen_d;
      talk_q   <= talk_d;
      trig_q   <= trig_d;
      set_q    <= set_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  always_comb begin
    remote_led      = remote_q;
    talk_led        = talk_q;
    listen_led      = listen_q;
    panel_locked    = llo_q;
    trigger_reading = trig_q;
    settings        = set_q;
  end
endmodule

//--- hw/gghd_pkg.sv
// Constants, types and defaults shared by both ends of the general command link.
// -------------------------------------------------------------------------
// Overview of operation
// - REN alone never sets remote; addressing does.
// - Controller asserts REN, then addresses listener.
// - IFC forces talker/listener idle and local.
// - IFC turns off talk and listen indicators.
// - Controller holds IFC at least 100 us.
// - Lockout ignores all panel controls.
// - LLO accepted only while REN asserted.
// - Only REN false clears lockout; GTL never.
// - Controller sends LLO 0x11 under ATN, unaddressed.
// - Controller sends GTL after listen addressing.
// - GTL while listening returns to local.
// - DCL clears unaddressed to power-up defaults.
// - Controller sends DCL 0x14 under ATN.
// - SDC clears only when addressed to listen.
// - Device clear loads the power-up settings.
// - GET while listening triggers one-shot modes only.
// - Controller sends GET after listen addressing.
// - Default primary address is 27.
// -------------------------------------------------------------------------
package gghd_pkg;

  // -----------------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 25;
  localparam int IFC_MIN_NS        = 100_000;
  localparam int IFC_CYCLES        = (IFC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_PHASE_CYCLES = 4;

  // -----------------------------------------------------------------------
  // Bus command bytes and address groups
  // -----------------------------------------------------------------------
  localparam logic [4:0] DEFAULT_PRIMARY_ADDR = 5'h1B;
  localparam logic [4:0] UNADDR_CODE          = 5'h1F;
  localparam logic [7:0] CMD_GTL              = 8'h01;
  localparam logic [7:0] CMD_SDC              = 8'h04;
  localparam logic [7:0] CMD_GET              = 8'h08;
  localparam logic [7:0] CMD_LLO              = 8'h11;
  localparam logic [7:0] CMD_DCL              = 8'h14;
  localparam logic [2:0] LISTEN_GROUP         = 3'h1;
  localparam logic [2:0] TALK_GROUP           = 3'h2;

  // -----------------------------------------------------------------------
  // Controller registers
  // -----------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  REG_CMD_OFS     = 8'h04;
  localparam logic [7:0]  REG_STATUS_OFS  = 8'h08;
  localparam int          CTRL_REN_BIT    = 0;
  localparam int          CTRL_ADDR_LSB   = 8;
  localparam int          CMD_BYTE_LSB    = 0;
  localparam int          CMD_OP_LSB      = 8;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_IFC_BIT    = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_1B00;

  typedef enum logic [1:0] {
    op_universal   = 2'b00,
    op_addressed   = 2'b01,
    op_ifc         = 2'b10,
    op_listen_only = 2'b11
  } gghd_op_type;

  // -----------------------------------------------------------------------
  // Instrument settings
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    trigger_mode_code0               = 3'h0,
    trigger_mode_code1               = 3'h1,
    one_shot_talk_trigger_mode       = 3'h2,
    one_shot_get_trigger_mode        = 3'h3,
    trigger_mode_code4               = 3'h4,
    trigger_mode_code5               = 3'h5,
    continuous_external_trigger_mode = 3'h6,
    trigger_mode_code7               = 3'h7
  } gghd_trig_type;

  typedef struct packed {
    logic [1:0]    func;
    logic          autorange;
    logic          zero_check;
    logic          zero_correct;
    logic          suppress;
    gghd_trig_type trig;
    logic          source_on;
    logic [1:0]    read_mode;
    logic [1:0]    data_format;
    logic [1:0]    display;
    logic [2:0]    data_store;
    logic [7:0]    srq_mask;
    logic [1:0]    eoi_holdoff;
    logic [2:0]    terminator;
  } gghd_settings_type;

  localparam logic [1:0] volts_function_default       = 2'h0;
  localparam logic       autorange_default            = 1'b1;
  localparam logic       zero_check_on_default        = 1'b1;
  localparam logic       zero_correct_off_default     = 1'b0;
  localparam logic [1:0] electrometer_read_default    = 2'h0;
  localparam logic [1:0] prefix_no_suffix_format      = 2'h0;
  localparam logic [1:0] electrometer_display_default = 2'h0;
  localparam logic [2:0] data_store_off_default       = 3'h7;
  localparam logic [7:0] service_request_off_default  = 8'h00;

  localparam gghd_settings_type SETTINGS_RESET = '{
    func:         volts_function_default,
    autorange:    autorange_default,
    zero_check:   zero_check_on_default,
    zero_correct: zero_correct_off_default,
    suppress:     1'b0,
    trig:         continuous_external_trigger_mode,
    source_on:    1'b0,
    read_mode:    electrometer_read_default,
    data_format:  prefix_no_suffix_format,
    display:      electrometer_display_default,
    data_store:   data_store_off_default,
    srq_mask:     service_request_off_default,
    eoi_holdoff:  2'h0,
    terminator:   3'h0
  };

endpackage

//--- hw/gghd_bus_if.sv
// Interface joining the bus controller and the instrument.
`timescale 1ns/1ps
interface gghd_bus_if;
  logic       atn;
  logic       ren;
  logic       ifc;
  logic       dav;
  logic [7:0] dio;

  modport ctl (
    output atn,
    output ren,
    output ifc,
    output dav,
    output dio
  );

  modport dev (
    input atn,
    input ren,
    input ifc,
    input dav,
    input dio
  );
endinterface

//--- hw/gghd_cmd_decode.sv
// Combinational decoder for command and address bytes taken under ATN.
`timescale 1ns/1ps
module gghd_cmd_decode (
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_valid,
  input  wire logic [4:0] my_addr,
  output logic            is_mla,
  output logic            is_unl,
  output logic            is_mta,
  output logic            is_untalk,
  output logic            is_gtl,
  output logic            is_sdc,
  output logic            is_get,
  output logic            is_llo,
  output logic            is_dcl
);
  import gghd_pkg::*;

  logic lag;
  logic tag;

  always_comb begin
    lag       = cmd_valid && (cmd_byte[7:5] == LISTEN_GROUP);
    tag       = cmd_valid && (cmd_byte[7:5] == TALK_GROUP);
    is_mla    = lag && (cmd_byte[4:0] == my_addr);
    is_unl    = lag && (cmd_byte[4:0] == UNADDR_CODE);
    is_mta    = tag && (cmd_byte[4:0] == my_addr);
    // A foreign talk address or untalk both drop the talker role.
    is_untalk = tag && (cmd_byte[4:0] != my_addr);
    is_gtl    = cmd_valid && (cmd_byte == CMD_GTL);
    is_sdc    = cmd_valid && (cmd_byte == CMD_SDC);
    is_get    = cmd_valid && (cmd_byte == CMD_GET);
    is_llo    = cmd_valid && (cmd_byte == CMD_LLO);
    is_dcl    = cmd_valid && (cmd_byte == CMD_DCL);
  end
endmodule

//--- hw/gghd_controller.sv
// Bus controller end: APB registers drive command and interface-clear sequences.
`timescale 1ns/1ps
module gghd_controller (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  gghd_bus_if.ctl          bus
);
  import gghd_pkg::*;

  if (BYTE_PHASE_CYCLES < 3 || IFC_CYCLES > 4096) begin : g_bad_phase
    $error("Timing counts do not suit the sequencer.");
  end

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01,
    st_byte = 2'b10,
    st_ifc  = 2'b11
  } gghd_cstate_type;

  localparam logic [11:0] PH_END   = 12'(BYTE_PHASE_CYCLES - 1);
  localparam logic [11:0] BYTE_END = 12'(2 * BYTE_PHASE_CYCLES - 1);
  localparam logic [11:0] IFC_END  = 12'(IFC_CYCLES - 1);

  // -----------------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------------
  // No wait state: the answer is registered in the setup cycle.
  gghd_cstate_type st_q, st_d;
  logic [31:0]     ctrl_q, ctrl_d, cmd_q, cmd_d, rdata_d;
  logic [11:0]     cnt_q, cnt_d;
  logic            rdy_q, rdy_d, err_q, err_d, done, mapped;
  logic            atn_q, atn_d, ifc_q, ifc_d, dav_q, dav_d;
  logic [7:0]      dio_q, dio_d;
  logic [31:0]     rdata_q;
  gghd_op_type     op;

  always_comb begin
    mapped  = (paddr == REG_CTRL_OFS) || (paddr == REG_CMD_OFS) ||
              (paddr == REG_STATUS_OFS);
    rdy_d   = psel && !penable;
    err_d   = psel && !penable && !mapped;
    done    = psel && penable && rdy_q;
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL_OFS: rdata_d = ctrl_q;
      REG_CMD_OFS:  rdata_d = cmd_q;
      REG_STATUS_OFS: begin
        rdata_d[STAT_BUSY_BIT] = (st_q != st_idle);
        rdata_d[STAT_IFC_BIT]  = ifc_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
    ctrl_d = ctrl_q;
    if (done && pwrite && paddr == REG_CTRL_OFS) begin
      ctrl_d = pwdata;
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 12'h001;
    cmd_d = cmd_q;
    atn_d = atn_q;
    ifc_d = ifc_q;
    dav_d = dav_q;
    dio_d = dio_q;
    op    = gghd_op_type'(cmd_q[CMD_OP_LSB +: 2]);
    unique case (st_q)
      st_idle: begin
        cnt_d = 12'h000;
        // Commands written while busy are dropped.
        if (done && pwrite && paddr == REG_CMD_OFS) begin
          cmd_d = pwdata;
          op    = gghd_op_type'(pwdata[CMD_OP_LSB +: 2]);
          if (op == op_ifc) begin
            st_d  = st_ifc;
            ifc_d = 1'b1;
          end else if (op == op_universal) begin
            st_d  = st_byte;
            atn_d = 1'b1;
            dav_d = 1'b1;
            dio_d = pwdata[CMD_BYTE_LSB +: 8];
          end else begin
            st_d  = st_addr;
            atn_d = 1'b1;
            dav_d = 1'b1;
            dio_d = {LISTEN_GROUP, ctrl_q[CTRL_ADDR_LSB +: 5]};
          end
        end
      end
      st_addr, st_byte: begin
        if (cnt_q == PH_END) begin
          dav_d = 1'b0;
        end
        if (cnt_q == BYTE_END) begin
          cnt_d = 12'h000;
          if (st_q == st_addr && op == op_addressed) begin
            st_d  = st_byte;
            dav_d = 1'b1;
            dio_d = cmd_q[CMD_BYTE_LSB +: 8];
          end else begin
            st_d  = st_idle;
            atn_d = 1'b0;
          end
        end
      end
      st_ifc: begin
        if (cnt_q == IFC_END) begin
          st_d  = st_idle;
          ifc_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= st_idle;
      cnt_q   <= 12'h000;
      ctrl_q  <= CTRL_RESET;
      cmd_q   <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      atn_q   <= 1'b0;
      ifc_q   <= 1'b0;
      dav_q   <= 1'b0;
      dio_q   <= 8'h00;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ctrl_q  <= ctrl_d;
      cmd_q   <= cmd_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
      atn_q   <= atn_d;
      ifc_q   <= ifc_d;
      dav_q   <= dav_d;
      dio_q   <= dio_d;
    end
  end

  always_comb begin
    prdata  = rdata_q;
    pready  = rdy_q;
    pslverr = err_q;
    bus.atn = atn_q;
    bus.ren = ctrl_q[CTRL_REN_BIT];
    bus.ifc = ifc_q;
    bus.dav = dav_q;
    bus.dio = dio_q;
  end
endmodule

//--- dv/gghd_properties.sv
// Concurrent checks on the link between the two ends and on the device outputs.
`timescale 1ns/1ps
module gghd_properties #(
  parameter logic [4:0] PRIMARY_ADDR = gghd_pkg::DEFAULT_PRIMARY_ADDR
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        atn,
  input wire logic                        ren,
  input wire logic                        ifc,
  input wire logic                        dav,
  input wire logic [7:0]                  dio,
  input wire logic                        remote_led,
  input wire logic                        talk_led,
  input wire logic                        listen_led,
  input wire logic                        panel_locked,
  input wire logic                        trigger_reading,
  input wire gghd_pkg::gghd_settings_type settings
);
  import gghd_pkg::*;
  // -----------------------------------------------------------------------
  // Helper logic
  // -----------------------------------------------------------------------
  // The counter runs to 8191, about twice the 4000-cycle clear length, so no wrap can fake a pass.
  logic [12:0] ifc_cnt_q;
  logic [12:0] ifc_cnt_d;
  always_comb begin
    ifc_cnt_d = ifc ? ifc_cnt_q + 13'h1 : 13'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifc_cnt_q <= 13'h0;
    end else begin
      ifc_cnt_q <= ifc_cnt_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmd(logic [7:0] b);
    $rose(dav) && atn && dio == b;
  endsequence
  sequence s_heard(logic [7:0] b);
    $past(atn, 3) && $past(dio, 3) == b;
  endsequence
  // -----------------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------------
  AST_IFC_HOLD: assert property ($fell(ifc) |-> ifc_cnt_q >= IFC_CYCLES)
    else $error("interface clear released too early");
  AST_IFC_IDLE: assert property (ifc [*6] |->
    !talk_led && !listen_led && !remote_led)
    else $error("interface clear left an indicator lit");
  AST_REMOTE_CAUSE: assert property ($rose(remote_led) |->
    ren ##0 s_heard({LISTEN_GROUP, PRIMARY_ADDR}))
    else $error("remote entered without listen addressing");
  AST_LLO_REN: assert property ($rose(panel_locked) |-> ren ##0 s_heard(CMD_LLO))
    else $error("lockout set without enable or command");
  AST_LOCK_KEEP: assert property (panel_locked && ren |=> panel_locked)
    else $error("lockout dropped while enable held");
  AST_LOCK_FREE: assert property ($fell(ren) && panel_locked |-> ##[1:6] !panel_locked)
    else $error("lockout kept after enable fell");
  AST_GTL_LOCAL: assert property (s_cmd(CMD_GTL) ##0 listen_led |-> ##[1:6] !remote_led)
    else $error("go to local ignored");
  AST_DCL: assert property (s_cmd(CMD_DCL) |-> ##[1:6] settings == SETTINGS_RESET)
    else $error("device clear did not restore defaults");
  AST_SDC: assert property (s_cmd(CMD_SDC) ##0 listen_led |->
    ##[1:6] settings == SETTINGS_RESET)
    else $error("selective clear did not restore defaults");
  AST_GET: assert property ($rose(trigger_reading) |-> listen_led &&
    (settings.trig == one_shot_talk_trigger_mode || settings.trig == one_shot_get_trigger_mode)
    ##0 s_heard(CMD_GET))
    else $error("reading started without a valid trigger");
endmodule

//--- dv/gpib_general_command_handler_bench.sv
// Self-checking bench with controller and instrument joined over the link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module gpib_general_command_handler_bench;
  import gghd_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              panel_local_key = 1'b0;
  logic              panel_set_we = 1'b0;
  gghd_settings_type panel_set_data = SETTINGS_RESET;
  logic              remote_led;
  logic              talk_led;
  logic              listen_led;
  logic              panel_locked;
  logic              trigger_reading;
  gghd_settings_type settings;
  int                num_errors = 0;
  int                checks_done = 0;
  logic              snap_q = 1'b0;
  logic [7:0]        trig_seen = 8'h00;
  logic [43:0]       exq[$];
  logic [32:0]       rdq[$];
  logic [43:0]       exp_v;
  logic [32:0]       exp_r;
  logic              e_rem = 1'b0;
  logic              e_talk = 1'b0;
  logic              e_lis = 1'b0;
  logic              e_lock = 1'b0;
  logic [7:0]        e_trig = 8'h00;
  gghd_settings_type e_set = SETTINGS_RESET;
  gghd_settings_type rs;
  gghd_bus_if bus_if ();
  gghd_controller gghd_controller_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_if));
  gghd_device gghd_device_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if),
    .panel_local_key(panel_local_key), .panel_set_we(panel_set_we),
    .panel_set_data(panel_set_data), .remote_led(remote_led), .talk_led(talk_led),
    .listen_led(listen_led), .panel_locked(panel_locked),
    .trigger_reading(trigger_reading), .settings(settings));
  gghd_properties gghd_properties_inst (.pclk(pclk), .presetn(presetn), .atn(bus_if.atn),
    .ren(bus_if.ren), .ifc(bus_if.ifc), .dav(bus_if.dav), .dio(bus_if.dio),
    .remote_led(remote_led), .talk_led(talk_led), .listen_led(listen_led),
    .panel_locked(panel_locked), .trigger_reading(trigger_reading), .settings(settings));
  always #12.5 pclk = ~pclk;
  // -----------------------------------------------------------------------
  // Monitor
  // -----------------------------------------------------------------------
  always @(posedge pclk) begin
    if (trigger_reading === 1'b1) begin
      trig_seen <= trig_seen + 8'h01;
    end
    if (snap_q) begin
      exp_v = exq.pop_front();
      `CHK("remote_led", exp_v[43], remote_led)
      `CHK("talk_led", exp_v[42], talk_led)
      `CHK("listen_led", exp_v[41], listen_led)
      `CHK("panel_locked", exp_v[40], panel_locked)
      `CHK("trigger count", exp_v[39:32], trig_seen)
      `CHK("settings", exp_v[31:0], settings)
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_r = rdq.pop_front();
      `CHK("apb read", exp_r, {pslverr, prdata})
    end
  end
  // -----------------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic cmd(input gghd_op_type op, input logic [7:0] b);
    apb(REG_CMD_OFS, 1'b1, {22'h0, op, b});
    rd(REG_STATUS_OFS, {31'h0, op == op_ifc, 1'b1});
    repeat (op == op_ifc ? 4010 : 24) @(posedge pclk);
    rd(REG_STATUS_OFS, 33'h0);
  endtask
  task automatic ctrl(input logic r);
    apb(REG_CTRL_OFS, 1'b1, CTRL_RESET | {31'h0, r});
    repeat (8) @(posedge pclk);
  endtask
  task automatic panel(input gghd_settings_type s);
    @(posedge pclk);
    panel_set_we <= 1'b1;
    panel_set_data <= s;
    @(posedge pclk);
    panel_set_we <= 1'b0;
    repeat (3) @(posedge pclk);
    if (!e_rem && !e_lock) e_set = s;
  endtask
  task automatic done(input string nm);
    @(posedge pclk);
    exq.push_back({e_rem, e_talk, e_lis, e_lock, e_trig, e_set});
    snap_q <= 1'b1;
    @(posedge pclk);
    snap_q <= 1'b0;
    $display("test %s done", nm);
  endtask
  // -----------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    results;
  end
  initial begin
    void'($urandom(87));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(REG_CTRL_OFS, {1'b0, CTRL_RESET});
    rd(8'hFC, {1'b1, 32'h0});
    done("reset");
    ctrl(1'b1);
    done("ren_alone");
    cmd(op_listen_only, 8'h00);
    e_rem = 1'b1;
    e_lis = 1'b1;
    rs = gghd_settings_type'($urandom());
    panel(rs);
    done("remote");
    for (int m = 0; m < 8; m++) begin
      cmd(op_addressed, CMD_GTL);
      e_rem = 1'b0;
      rs = gghd_settings_type'($urandom());
      rs.trig = gghd_trig_type'(m);
      panel(rs);
      cmd(op_addressed, CMD_GET);
      e_rem = 1'b1;
      if (m == 2 || m == 3) e_trig = e_trig + 8'h01;
      done("trigger_mode");
    end
    cmd(op_addressed, CMD_SDC);
    e_set = SETTINGS_RESET;
    done("sdc");
    cmd(op_addressed, CMD_GTL);
    e_rem = 1'b0;
    rs = gghd_settings_type'($urandom());
    panel(rs);
    cmd(op_universal, {LISTEN_GROUP, UNADDR_CODE});
    e_lis = 1'b0;
    cmd(op_universal, CMD_SDC);
    done("sdc_unaddressed");
    cmd(op_universal, CMD_DCL);
    e_set = SETTINGS_RESET;
    done("dcl");
    ctrl(1'b0);
    cmd(op_universal, CMD_LLO);
    done("llo_no_ren");
    ctrl(1'b1);
    cmd(op_universal, CMD_LLO);
    e_lock = 1'b1;
    cmd(op_addressed, CMD_GTL);
    e_lis = 1'b1;
    rs = gghd_settings_type'($urandom());
    panel(rs);
    done("gtl_locked");
    cmd(op_listen_only, 8'h00);
    e_rem = 1'b1;
    @(posedge pclk);
    panel_local_key <= 1'b1;
    @(posedge pclk);
    panel_local_key <= 1'b0;
    cmd(op_universal, {LISTEN_GROUP, UNADDR_CODE});
    e_lis = 1'b0;
    cmd(op_universal, {TALK_GROUP, DEFAULT_PRIMARY_ADDR});
    e_talk = 1'b1;
    done("talker_locked");
    cmd(op_ifc, 8'h00);
    e_rem = 1'b0;
    e_talk = 1'b0;
    done("ifc");
    ctrl(1'b0);
    e_lock = 1'b0;
    done("unlock");
    results;
  end
endmodule
